// >>> ulpsr_regs.sv
// Function
// - At power-up each PHY drive field loads from EEPROM, else OTP, else zero.
// - USB reset or light reset reloads the drive fields from the last image while protection is inactive.
// - Swing bit 6, margin 5:3, de-emphasis 2:1, buffer mode bit 0, upper RO.
// - In compliance mode the PHY de-emphasis comes from link training.
// - Drive fields change by software only while protection allows it.
// - Buffer mode bit is stored and read back but drives no behaviour.
// - Shallow latency register holds 23:16 and 7:0, read-only, set by host.
// - Deep latency register holds 31:16 and 15:0, read-only, set by host.
// - Change flags 5:0 combine into the link status interrupt bit.
// - Live feature states read at bits 20 to 16 of the status register.
// - A host select request updates both latencies and sets flag bit 5.
// - Host feature set or clear raises its sticky flag at bits 4 to 0.
// - Status events reach the interrupt endpoint only when enabled.
//
// Top: link power status register group behind an AHB-Lite slave port.
// Assumes hready equals hreadyout (single slave) and word-sized transfers.
module ulpsr_regs
	import ulpsr_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic usb_reset,
	input wire logic light_reset,
	input wire logic cfg_valid,
	input wire logic [1:0] cfg_src,
	input wire logic [6:0] cfg_image,
	input wire logic protect_active,
	input wire logic compliance_mode,
	input wire logic [1:0] link_training_deemph,
	input wire logic set_sel_stb,
	input wire logic [7:0] set_sel_u1_pel,
	input wire logic [7:0] set_sel_u1_sel,
	input wire logic [15:0] set_sel_u2_pel,
	input wire logic [15:0] set_sel_u2_sel,
	input wire logic [4:0] feat_stb,
	input wire logic [4:0] feat_val,
	output logic phy_tx_swing,
	output logic [2:0] phy_tx_margin,
	output logic [1:0] phy_tx_deemph,
	output logic phy_elastic_mode,
	output logic link_status_irq,
	output logic intep_link_event,
	output logic irq
);
	typedef enum logic [2:0] {
		ULPSR_BOOT = 3'b001,
		ULPSR_WAIT = 3'b010,
		ULPSR_RUN = 3'b100
	} ulpsr_state_t;

	ulpsr_evt_if evt ();

	ulpsr_state_t state_q;
	logic [6:0] phy_q;
	logic [6:0] image_q;
	logic ph_act_q;
	logic ph_wr_q;
	logic [7:0] ph_addr_q;
	logic link_status_irq_enable_q;
	logic [1:0] int_sts_q;
	logic [1:0] int_en_q;
	logic [7:0] u1_pel_q;
	logic [7:0] u1_sel_q;
	logic [15:0] u2_pel_q;
	logic [15:0] u2_sel_q;
	logic [4:0] feat_q;
	logic wr_en;
	logic [31:0] rd_d;
	logic [1:0] int_evt;
	logic flags_any;
	logic flags_any_q;
	logic reload;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction : hit

	// Always zero-wait, always OKAY
	assign hreadyout = 1'h1;
	assign hresp = 1'h0;
	assign wr_en = ph_act_q && ph_wr_q;
	assign reload = usb_reset || light_reset;

	// Address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_act_q <= 1'h0;
			ph_wr_q <= 1'h0;
			ph_addr_q <= 8'h00;
		end else if (hready) begin
			ph_act_q <= hsel && htrans == ULPSR_HTRANS_NONSEQ;
			ph_wr_q <= hwrite;
			ph_addr_q <= haddr[7:0];
		end
	end

	// Image tracker: holds most recent config load, zero when no source
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			image_q <= ULPSR_PHY_ZERO;
		end else if (cfg_valid) begin
			image_q <= (cfg_src == ULPSR_CFG_NONE) ? ULPSR_PHY_ZERO : cfg_image;
		end
	end

	// Boot sequencing: drive fields take the image once config loads
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ULPSR_BOOT;
		end else begin
			unique case (state_q)
				ULPSR_BOOT: begin
					state_q <= ULPSR_WAIT;
				end
				ULPSR_WAIT: begin
					if (cfg_valid) begin
						state_q <= ULPSR_RUN;
					end
				end
				ULPSR_RUN: begin
					state_q <= ULPSR_RUN;
				end
				default: begin
					state_q <= ULPSR_BOOT;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phy_q <= ULPSR_PHY_ZERO;
		end else if (state_q == ULPSR_WAIT && cfg_valid) begin
			phy_q <= (cfg_src == ULPSR_CFG_NONE) ? ULPSR_PHY_ZERO : cfg_image;
		end else if (reload && !protect_active) begin
			// Protection also shields the fields from the reset reload
			phy_q <= image_q;
		end else if (wr_en && hit(ph_addr_q, ULPSR_OFF_PHY) && !protect_active) begin
			phy_q <= hwdata[6:0];
		end
	end

	assign phy_tx_swing = phy_q[ULPSR_SWING_POS];
	assign phy_tx_margin = phy_q[ULPSR_MARGIN_LSB +: 3];
	// Training owns de-emphasis during compliance
	assign phy_tx_deemph = compliance_mode ? link_training_deemph
		: phy_q[ULPSR_DEEMPH_LSB +: 2];
	// Mode bit is passed through only; nothing here acts on it
	assign phy_elastic_mode = phy_q[ULPSR_EBM_POS];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link_status_irq_enable_q <= 1'h0;
		end else if (wr_en && hit(ph_addr_q, ULPSR_OFF_CTRL)) begin
			link_status_irq_enable_q <= hwdata[ULPSR_IRQEN_POS];
		end
	end

	assign evt.sel_stb = set_sel_stb;
	assign evt.u1_pel = set_sel_u1_pel;
	assign evt.u1_sel = set_sel_u1_sel;
	assign evt.u2_pel = set_sel_u2_pel;
	assign evt.u2_sel = set_sel_u2_sel;
	assign evt.feat_stb = feat_stb;
	assign evt.feat_val = feat_val;
	assign evt.clr = (wr_en && hit(ph_addr_q, ULPSR_OFF_STS))
		? hwdata[5:0] : 6'h00;

	ulpsr_link_state u_state (
		.hclk(hclk),
		.hresetn(hresetn),
		.evt(evt),
		.u1_pel_q(u1_pel_q),
		.u1_sel_q(u1_sel_q),
		.u2_pel_q(u2_pel_q),
		.u2_sel_q(u2_sel_q),
		.feat_q(feat_q)
	);

	assign flags_any = |evt.flags;
	assign link_status_irq = flags_any;
	assign intep_link_event = flags_any && link_status_irq_enable_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_any_q <= 1'h0;
		end else begin
			flags_any_q <= flags_any;
		end
	end

	// Interrupt events: bit 0 select request, bit 1 feature change
	assign int_evt = {|feat_stb, set_sel_stb};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_sts_q <= 2'h0;
		end else begin
			int_sts_q <= (int_sts_q & ~((wr_en && hit(ph_addr_q, ULPSR_OFF_INT_CLR))
				? hwdata[1:0] : 2'h0)) | int_evt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_en_q <= 2'h0;
		end else if (wr_en && hit(ph_addr_q, ULPSR_OFF_INT_EN)) begin
			int_en_q <= hwdata[1:0];
		end
	end

	assign irq = |(int_sts_q & int_en_q);

	always_comb begin
		rd_d = 32'h0000_0000;
		unique case (haddr[7:0])
			ULPSR_OFF_PHY: rd_d[6:0] = phy_q;
			ULPSR_OFF_U1: rd_d = {8'h00, u1_pel_q, 8'h00, u1_sel_q};
			ULPSR_OFF_U2: rd_d = {u2_pel_q, u2_sel_q};
			ULPSR_OFF_STS: rd_d = {11'h000, feat_q, 10'h000, evt.flags};
			ULPSR_OFF_INT_STS: rd_d[1:0] = int_sts_q;
			ULPSR_OFF_INT_EN: rd_d[1:0] = int_en_q;
			ULPSR_OFF_CTRL: rd_d[ULPSR_IRQEN_POS] = link_status_irq_enable_q;
			default: rd_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans == ULPSR_HTRANS_NONSEQ && !hwrite) begin
			hrdata <= rd_d;
		end
	end

	reload_image_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(reload && !protect_active && !(state_q == ULPSR_WAIT && cfg_valid))
		|=> phy_q == $past(image_q))
		else $error("drive fields not reloaded from image");
	protect_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(protect_active && state_q == ULPSR_RUN) |=> $stable(phy_q))
		else $error("protected drive fields changed");
	deemph_src_a: assert property (@(posedge hclk) disable iff (!hresetn)
		compliance_mode |-> phy_tx_deemph == link_training_deemph)
		else $error("de-emphasis not from training in compliance");
	sts_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
		set_sel_stb |=> link_status_irq)
		else $error("status interrupt missing after select");
	ep_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!link_status_irq_enable_q |-> !intep_link_event)
		else $error("endpoint event while disabled");
	boot_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_q == ULPSR_WAIT && cfg_valid && cfg_src == ULPSR_CFG_NONE)
		|=> phy_q == ULPSR_PHY_ZERO)
		else $error("blank config did not give zero");
	mirror_rd_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(hready && hsel && htrans == ULPSR_HTRANS_NONSEQ && !hwrite
		&& haddr[7:0] == ULPSR_OFF_STS) |=> hrdata[20:16] == $past(feat_q))
		else $error("mirror bits read wrong");
	light_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(light_reset && !set_sel_stb) |=> $stable(u2_pel_q))
		else $error("latency lost on light reset");

	// Latency, mirror, flag and status event enable checks
	rise_cause_a: assert property (@(posedge hclk)
		disable iff (!hresetn) (flags_any && !flags_any_q)
		|-> $past(set_sel_stb || (|feat_stb)))
		else $error("change flag rose without host event");
	shallow_load_a: assert property (@(posedge hclk)
		disable iff (!hresetn) set_sel_stb
		|=> u1_pel_q == $past(set_sel_u1_pel)
		&& u1_sel_q == $past(set_sel_u1_sel))
		else $error("shallow latency not loaded");
	shallow_ro_a: assert property (@(posedge hclk)
		disable iff (!hresetn) (wr_en && hit(ph_addr_q, ULPSR_OFF_U1)
		&& !set_sel_stb) |=> $stable(u1_pel_q) && $stable(u1_sel_q))
		else $error("software write changed shallow latency");
	deep_load_a: assert property (@(posedge hclk)
		disable iff (!hresetn) set_sel_stb
		|=> u2_pel_q == $past(set_sel_u2_pel))
		else $error("deep latency not loaded");
	deep_read_a: assert property (@(posedge hclk)
		disable iff (!hresetn) (hready && hsel && !hwrite
		&& htrans == ULPSR_HTRANS_NONSEQ && haddr[7:0] == ULPSR_OFF_U2)
		|=> hrdata == {$past(u2_pel_q), $past(u2_sel_q)})
		else $error("deep latency read wrong");
	wake_flag_a: assert property (@(posedge hclk)
		disable iff (!hresetn) feat_stb[4] |=> evt.flags[4])
		else $error("wake change not flagged");
	wake_mirror_a: assert property (@(posedge hclk)
		disable iff (!hresetn) feat_stb[4]
		|=> feat_q[4] == $past(feat_val[4]))
		else $error("wake mirror not updated");
	light_mirror_a: assert property (@(posedge hclk)
		disable iff (!hresetn) (light_reset && !(|feat_stb))
		|=> $stable(feat_q))
		else $error("feature mirror lost on light reset");
	flag_clear_a: assert property (@(posedge hclk)
		disable iff (!hresetn) (wr_en && hit(ph_addr_q, ULPSR_OFF_STS)
		&& hwdata[ULPSR_SEL_FLAG_POS] && !set_sel_stb)
		|=> !evt.flags[ULPSR_SEL_FLAG_POS])
		else $error("select flag not cleared by write one");
	ep_follow_a: assert property (@(posedge hclk)
		disable iff (!hresetn) (link_status_irq && link_status_irq_enable_q)
		|-> intep_link_event)
		else $error("enabled status event not reported");
	ctrl_read_a: assert property (@(posedge hclk)
		disable iff (!hresetn) (hready && hsel && !hwrite
		&& htrans == ULPSR_HTRANS_NONSEQ && haddr[7:0] == ULPSR_OFF_CTRL)
		|=> hrdata[ULPSR_IRQEN_POS] == $past(link_status_irq_enable_q))
		else $error("status enable read wrong");

	// Drive control and interrupt checks
	drive_map_a: assert property (@(posedge hclk)
		disable iff (!hresetn) phy_tx_swing == phy_q[ULPSR_SWING_POS]
		&& phy_tx_margin == phy_q[ULPSR_MARGIN_LSB +: 3])
		else $error("drive outputs do not follow the register");
	sw_write_a: assert property (@(posedge hclk)
		disable iff (!hresetn) (wr_en && hit(ph_addr_q, ULPSR_OFF_PHY)
		&& !protect_active && !reload && state_q == ULPSR_RUN)
		|=> phy_q == $past(hwdata[6:0]))
		else $error("drive control write lost");
	upper_zero_a: assert property (@(posedge hclk)
		disable iff (!hresetn) (hready && hsel && !hwrite
		&& htrans == ULPSR_HTRANS_NONSEQ && haddr[7:0] == ULPSR_OFF_PHY)
		|=> hrdata[31:7] == 25'h000_0000)
		else $error("reserved drive control bits read nonzero");
	deemph_reg_a: assert property (@(posedge hclk)
		disable iff (!hresetn) !compliance_mode
		|-> phy_tx_deemph == phy_q[ULPSR_DEEMPH_LSB +: 2])
		else $error("de-emphasis not from register outside compliance");
	boot_image_a: assert property (@(posedge hclk)
		disable iff (!hresetn)
		(state_q == ULPSR_WAIT && cfg_valid && cfg_src != ULPSR_CFG_NONE)
		|=> phy_q == $past(cfg_image))
		else $error("boot load did not take the image");
	int_set_a: assert property (@(posedge hclk)
		disable iff (!hresetn) set_sel_stb |=> int_sts_q[0])
		else $error("select event not latched");
	int_clr_a: assert property (@(posedge hclk)
		disable iff (!hresetn) (wr_en && hit(ph_addr_q, ULPSR_OFF_INT_CLR)
		&& hwdata[1] && !(|feat_stb)) |=> !int_sts_q[1])
		else $error("feature event not cleared");
	irq_mask_a: assert property (@(posedge hclk)
		disable iff (!hresetn) int_en_q == 2'h0 |-> !irq)
		else $error("interrupt while all sources masked");
endmodule : ulpsr_regs

// >>> ulpsr_pkg.sv
// Package for the link power status register group: offsets, fields, resets.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
package ulpsr_pkg;
	localparam logic [7:0] ULPSR_OFF_PHY = 8'h9C;
	localparam logic [7:0] ULPSR_OFF_U1 = 8'hA0;
	localparam logic [7:0] ULPSR_OFF_U2 = 8'hA4;
	localparam logic [7:0] ULPSR_OFF_STS = 8'hA8;
	localparam logic [7:0] ULPSR_OFF_INT_STS = 8'hB8;
	localparam logic [7:0] ULPSR_OFF_INT_EN = 8'hBC;
	localparam logic [7:0] ULPSR_OFF_INT_CLR = 8'hC4;
	localparam logic [7:0] ULPSR_OFF_CTRL = 8'hC8;
	localparam int ULPSR_SWING_POS = 6;
	localparam int ULPSR_MARGIN_LSB = 3;
	localparam int ULPSR_DEEMPH_LSB = 1;
	localparam int ULPSR_EBM_POS = 0;
	localparam int ULPSR_SEL_FLAG_POS = 5;
	localparam int ULPSR_MIRROR_LSB = 16;
	localparam int ULPSR_IRQEN_POS = 20;
	localparam logic [6:0] ULPSR_PHY_ZERO = 7'h00;
	localparam logic [5:0] ULPSR_FLAGS_RST = 6'h00;
	localparam logic [4:0] ULPSR_FEAT_RST = 5'h00;
	localparam logic [7:0] ULPSR_LAT8_RST = 8'h00;
	localparam logic [15:0] ULPSR_LAT16_RST = 16'h0000;
	localparam logic [1:0] ULPSR_HTRANS_NONSEQ = 2'h2;
	typedef enum logic [1:0] {
		ULPSR_CFG_NONE = 2'h0,
		ULPSR_CFG_EEPROM = 2'h1,
		ULPSR_CFG_OTP = 2'h2
	} ulpsr_cfg_src_t;
endpackage : ulpsr_pkg

// >>> ulpsr_evt_if.sv
// Interface carrying host-side link events into the status block.
// Assumes a single hclk domain.
interface ulpsr_evt_if;
	logic sel_stb;
	logic [7:0] u1_pel;
	logic [7:0] u1_sel;
	logic [15:0] u2_pel;
	logic [15:0] u2_sel;
	logic [4:0] feat_stb;
	logic [4:0] feat_val;
	logic [5:0] flags;
	logic [5:0] clr;
	modport src (output sel_stb, u1_pel, u1_sel, u2_pel, u2_sel,
		feat_stb, feat_val, clr, input flags);
	modport dst (input sel_stb, u1_pel, u1_sel, u2_pel, u2_sel,
		feat_stb, feat_val, clr, output flags);
endinterface : ulpsr_evt_if

// >>> ulpsr_link_state.sv
// Link state store: latencies, live feature mirrors and sticky change flags.
// Assumes request strobes are one-cycle pulses synchronous to hclk.
module ulpsr_link_state
	import ulpsr_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	ulpsr_evt_if.dst evt,
	output logic [7:0] u1_pel_q,
	output logic [7:0] u1_sel_q,
	output logic [15:0] u2_pel_q,
	output logic [15:0] u2_sel_q,
	output logic [4:0] feat_q
);
	logic [5:0] flags_q;
	logic [5:0] set_d;

	assign evt.flags = flags_q;
	// Any host set or clear counts as a change
	assign set_d = {evt.sel_stb, evt.feat_stb};

	// Latencies survive light reset: only hresetn clears them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			u1_pel_q <= ULPSR_LAT8_RST;
			u1_sel_q <= ULPSR_LAT8_RST;
			u2_pel_q <= ULPSR_LAT16_RST;
			u2_sel_q <= ULPSR_LAT16_RST;
		end else if (evt.sel_stb) begin
			u1_pel_q <= evt.u1_pel;
			u1_sel_q <= evt.u1_sel;
			u2_pel_q <= evt.u2_pel;
			u2_sel_q <= evt.u2_sel;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			feat_q <= ULPSR_FEAT_RST;
		end else begin
			feat_q <= (feat_q & ~evt.feat_stb) | (evt.feat_val & evt.feat_stb);
		end
	end

	// Set wins over a same-cycle clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_q <= ULPSR_FLAGS_RST;
		end else begin
			flags_q <= (flags_q & ~evt.clr) | set_d;
		end
	end

	sel_update_a: assert property (@(posedge hclk) disable iff (!hresetn)
		evt.sel_stb |=> flags_q[ULPSR_SEL_FLAG_POS] && u2_sel_q == $past(evt.u2_sel))
		else $error("latency or select flag not updated");
	feat_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
		evt.feat_stb[0] |=> flags_q[0] && feat_q[0] == $past(evt.feat_val[0]))
		else $error("feature change not flagged");
	flag_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(flags_q[1] && !evt.clr[1]) |=> flags_q[1])
		else $error("change flag lost without clear");
	lat_stable_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!evt.sel_stb |=> $stable(u1_pel_q) && $stable(u1_sel_q))
		else $error("latency changed without select");
endmodule : ulpsr_link_state

// >>> ulpsr_host_model.sv
// Host and PHY side model: link events and config image loads.
// Assumes the register group samples every strobe on rising hclk.
module ulpsr_host_model (
	input wire logic hclk,
	output logic set_sel_stb,
	output logic [47:0] sel_data,
	output logic [4:0] feat_stb,
	output logic [4:0] feat_val,
	output logic cfg_valid,
	output logic [1:0] cfg_src,
	output logic [6:0] cfg_image
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		set_sel_stb = 1'h0;
		sel_data = 48'h0;
		feat_stb = 5'h00;
		feat_val = 5'h00;
		cfg_valid = 1'h0;
		cfg_src = 2'h0;
		cfg_image = 7'h00;
	end
	// Data lines show the inverse once the strobe has gone
	task sel(input logic [47:0] d);
		@(posedge hclk);
		set_sel_stb <= 1'h1;
		sel_data <= d;
		@(posedge hclk);
		set_sel_stb <= 1'h0;
		sel_data <= ~d;
	endtask : sel
	task feat(input int i, input logic v);
		@(posedge hclk);
		feat_stb <= 5'h01 << i;
		feat_val <= {5{v}};
		@(posedge hclk);
		feat_stb <= 5'h00;
		feat_val <= {5{~v}};
	endtask : feat
	task cfg(input logic [1:0] s, input logic [6:0] d);
		@(posedge hclk);
		cfg_valid <= 1'h1;
		cfg_src <= s;
		cfg_image <= d;
		@(posedge hclk);
		cfg_valid <= 1'h0;
		cfg_image <= ~d;
	endtask : cfg
endmodule : ulpsr_host_model

// >>> ulpsr_regs_tb.sv
// Testbench for the link power status register group.
// Assumes one 10 MHz hclk and the host model beside the block.
module ulpsr_regs_tb import ulpsr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, dph;
	logic [31:0] haddr, hwdata, hrdata, e;
	logic [1:0] htrans, link_training_deemph, cfg_src, de;
	logic usb_reset, light_reset, protect_active, compliance_mode;
	logic set_sel_stb, cfg_valid, sw, eb, lsi, iev, irq;
	logic [47:0] sd, sel;
	logic [4:0] feat_stb, feat_val;
	logic [6:0] cfg_image, drv;
	logic [2:0] mg;
	logic [31:0] exp_q[$];
	int n_mismatch = 0;
	int comparisons = 0;
	assign hready = hreadyout;
	assign drv = {sw, mg, de, eb};
	ulpsr_regs u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp,
		.usb_reset, .light_reset, .cfg_valid, .cfg_src, .cfg_image,
		.protect_active, .compliance_mode, .link_training_deemph,
		.set_sel_stb,
		.set_sel_u1_pel(sd[47:40]), .set_sel_u1_sel(sd[39:32]),
		.set_sel_u2_pel(sd[31:16]), .set_sel_u2_sel(sd[15:0]),
		.feat_stb, .feat_val, .phy_tx_swing(sw), .phy_tx_margin(mg),
		.phy_tx_deemph(de), .phy_elastic_mode(eb),
		.link_status_irq(lsi), .intep_link_event(iev), .irq);
	ulpsr_host_model host (.hclk, .set_sel_stb, .sel_data(sd), .feat_stb,
		.feat_val, .cfg_valid, .cfg_src, .cfg_image);
	initial begin
		hclk = 1'h0;
		forever #50 hclk = ~hclk;
	end
	task chk(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	task give_verdict;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict
	task rdy;
		int n;
		for (n = 0; n < 20; n++) begin
			@(posedge hclk);
			if (hready === 1'h1) break;
		end
		if (n == 20) begin
			n_mismatch++;
			give_verdict;
		end
	endtask : rdy
	// Single word transfer; on a read d is the expected data
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= ULPSR_HTRANS_NONSEQ;
		rdy;
		htrans <= 2'h0;
		hwdata <= d;
		dph <= ~w;
		if (!w) exp_q.push_back(d);
		rdy;
		dph <= 1'h0;
	endtask : bus
	task st;
		@(posedge hclk);
		#1;
	endtask : st
	task pulse(input logic u);
		@(posedge hclk);
		if (u) usb_reset <= 1'h1; else light_reset <= 1'h1;
		@(posedge hclk);
		usb_reset <= 1'h0;
		light_reset <= 1'h0;
	endtask : pulse
	always @(posedge hclk) begin
		if (dph === 1'h1) begin
			e = exp_q.pop_front();
			chk(hrdata, e);
			chk({31'h0, hresp}, 32'h0);
		end
	end
	initial begin
		hresetn = 1'h0;
		hsel = 1'h1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hwdata = 32'h0;
		dph = 1'h0;
		usb_reset = 1'h0;
		light_reset = 1'h0;
		protect_active = 1'h0;
		compliance_mode = 1'h0;
		link_training_deemph = 2'h0;
		void'($urandom(28));
		repeat (16) @(posedge hclk);
		hresetn <= 1'h1;
		repeat (4) @(posedge hclk);
		for (int i = 0; i < 4; i++) bus(0, ULPSR_OFF_PHY + 8'(4 * i), 0);
		host.cfg(ULPSR_CFG_EEPROM, 7'h5B);
		bus(0, ULPSR_OFF_PHY, 32'h5B);
		chk({25'h0, drv}, 32'h5B);
		host.cfg(ULPSR_CFG_OTP, 7'h22);
		bus(0, ULPSR_OFF_PHY, 32'h5B);
		bus(1, ULPSR_OFF_PHY, 32'hFFFF_FFAC);
		bus(0, ULPSR_OFF_PHY, 32'h2C);
		protect_active <= 1'h1;
		bus(1, ULPSR_OFF_PHY, 32'h0);
		protect_active <= 1'h0;
		bus(0, ULPSR_OFF_PHY, 32'h2C);
		pulse(1);
		bus(0, ULPSR_OFF_PHY, 32'h22);
		bus(1, ULPSR_OFF_PHY, 32'h7F);
		protect_active <= 1'h1;
		pulse(1);
		protect_active <= 1'h0;
		bus(0, ULPSR_OFF_PHY, 32'h7F);
		pulse(0);
		bus(0, ULPSR_OFF_PHY, 32'h22);
		compliance_mode <= 1'h1;
		link_training_deemph <= 2'h2;
		st;
		chk({25'h0, drv}, 32'h24);
		compliance_mode <= 1'h0;
		host.cfg(ULPSR_CFG_NONE, 7'h7F);
		pulse(1);
		bus(0, ULPSR_OFF_PHY, 32'h0);
		sel = {16'($urandom), $urandom};
		host.sel(sel);
		bus(0, ULPSR_OFF_U1, {8'h0, sel[47:40], 8'h0, sel[39:32]});
		bus(0, ULPSR_OFF_U2, sel[31:0]);
		bus(0, ULPSR_OFF_STS, 32'h20);
		chk({30'h0, lsi, iev}, 32'h2);
		bus(1, ULPSR_OFF_CTRL, 32'h0010_0000);
		st;
		chk({30'h0, lsi, iev}, 32'h3);
		bus(0, ULPSR_OFF_CTRL, 32'h0010_0000);
		bus(1, ULPSR_OFF_U1, 32'hFFFF_FFFF);
		pulse(0);
		bus(0, ULPSR_OFF_U1, {8'h0, sel[47:40], 8'h0, sel[39:32]});
		bus(1, ULPSR_OFF_STS, 32'h3F);
		for (int i = 0; i < 5; i++) host.feat(i, 1'h1);
		bus(0, ULPSR_OFF_STS, 32'h001F_001F);
		bus(1, ULPSR_OFF_STS, 32'h0);
		bus(0, ULPSR_OFF_STS, 32'h001F_001F);
		bus(1, ULPSR_OFF_STS, 32'h1F);
		st;
		chk({31'h0, lsi}, 32'h0);
		pulse(0);
		host.feat(2, 1'h0);
		bus(0, ULPSR_OFF_STS, 32'h001B_0004);
		bus(1, ULPSR_OFF_INT_EN, 32'h3);
		st;
		chk({31'h0, irq}, 32'h1);
		bus(1, ULPSR_OFF_INT_EN, 32'h0);
		st;
		chk({31'h0, irq}, 32'h0);
		bus(0, ULPSR_OFF_INT_STS, 32'h3);
		bus(1, ULPSR_OFF_INT_CLR, 32'h3);
		bus(1, ULPSR_OFF_INT_EN, 32'h3);
		bus(0, ULPSR_OFF_INT_STS, 32'h0);
		st;
		chk({31'h0, irq}, 32'h0);
		bus(0, 8'h10, 32'h0);
		st;
		give_verdict;
	end
endmodule : ulpsr_regs_tb
